// ### core/holdover_lock_detect_status.sv
// Purpose: holdover control, digital lock detect, dac flags, status pins
//          and loop dividers of a dual-loop clock conditioner
// Assumes: all inputs synchronous to core_clk; ticks are one-cycle pulses
// Notes:   settings are reached over the plain register port
//
// Summary of operation
// - force bit always enters holdover
// - loop1 lock drop enters holdover when enabled
// - tuning rail crossing enters holdover when enabled with tracking and manual dac on
// - holdover: pump off, loop1 lock low, flag
// - loop2 lock held if locked at entry
// - holdover dac: manual or last tracked value
// - holdover flag selectable on both status pins
// - mode disabled forces holdover exit unless force bit set
// - exit holdover once hold count reached and force bit clear
// - count comparisons inside the phase window
// - lock asserted when count reaches target
// - one outside comparison drops lock
// - pin shows loop1, loop2 or both locks
// - logic low selection, invertible general output
// - dac low and high trip flags
// - dac rail is low or high
// - dac locked only while tracking and close
// - loop1 dividers up to 16383
// - loop2 reference 4095, feedback 262143
// - loop2 prescaler two to eight
// - doubler counts both reference edges
// - tracked value updates every divided period outside holdover
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module holdover_lock_detect_status #(
  parameter int DAC_W  = 10,   // dac and tuning code width
  parameter int PERR_W = 8     // phase error magnitude width
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              rstn,
  // register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // phase comparisons of each loop
  input  wire logic              loop1_cmp_valid,
  input  wire logic [PERR_W-1:0] loop1_phase_err,
  input  wire logic              loop2_cmp_valid,
  input  wire logic [PERR_W-1:0] loop2_phase_err,
  // loop1 tuning level as a dac code
  input  wire logic [DAC_W-1:0]  tune_code,
  // divider inputs
  input  wire logic              loop1_ref_tick,
  input  wire logic              loop1_fb_tick,
  input  wire logic              oscillator_input,
  input  wire logic              loop2_fb_tick,
  // loop controls
  output logic                   loop1_charge_pump_en,
  output logic      [DAC_W-1:0]  dac_value,
  output holdover_pkg::flags_s   status_flags,
  // status pins
  output logic                   lock_status_pin,
  output logic                   holdover_status_pin,
  // divided phase detector pulses
  output logic                   loop1_r_pulse,
  output logic                   loop1_n_pulse,
  output logic                   loop2_r_pulse,
  output logic                   loop2_n_pulse
);

  // refuse widths the register fields cannot hold
  if (DAC_W < 1 || DAC_W > 16 || PERR_W < 1 || PERR_W > 8) begin : g_chk
    $error("holdover_lock_detect_status: unsupported width");
  end

  // whole state of the block
  typedef struct packed {
    logic [31:0]            rdata;      // read answer
    logic [7:0]             ctrl;       // control bits
    logic [DAC_W-1:0]       upper_trip; // dac_upper_trip
    logic [DAC_W-1:0]       lower_trip; // dac_lower_trip
    logic [DAC_W-1:0]       manual_val; // manual dac value
    logic [9:0]             dac_clk_div;// tracking update divider
    logic [PERR_W-1:0]      win1;       // loop1 window size
    logic [PERR_W-1:0]      win2;       // loop2 window size
    logic [13:0]            hold_cnt;   // loop1 count target
    logic [13:0]            cnt2;       // loop2 count target
    logic [12:0]            pinsel;     // both pin selectors
    logic [13:0]            r1_div;
    logic [13:0]            n1_div;
    logic [11:0]            r2_div;
    logic [3:0]             presc;
    logic [17:0]            n2_div;
    holdover_pkg::lockdet_s det1;       // loop1 detector
    holdover_pkg::lockdet_s det2;       // loop2 detector
    holdover_pkg::ho_state_e st;        // holdover state
    logic                   keep2;      // loop2 locked at entry
    logic [9:0]             trk_cnt;    // tracking divider count
    logic [DAC_W-1:0]       tracked;    // last tracked code
    logic [DAC_W-1:0]       dac;        // dac drive
    logic                   pump_en;    // loop1 pump enabled
    holdover_pkg::flags_s   flags;      // status flags
    logic                   lock_pin;
    logic                   hold_pin;
    logic [13:0]            r1_cnt;
    logic [13:0]            n1_cnt;
    logic [11:0]            r2_cnt;
    logic [3:0]             pre_cnt;
    logic [17:0]            n2_cnt;
    logic                   osc_prev;   // previous oscillator level
    logic [3:0]             pulses;     // r1 n1 r2 n2 divided pulses
  } state_s;

  state_s q;  // registered state
  state_s d;  // next state

  // one comparison step of a lock detector
  function automatic holdover_pkg::lockdet_s lock_step(
    input holdover_pkg::lockdet_s cur,
    input logic                   valid,
    input logic [PERR_W-1:0]      err,
    input logic [PERR_W-1:0]      win,
    input logic [13:0]            target
  );
    holdover_pkg::lockdet_s nx;
    logic [13:0]            tgt;
    nx  = cur;
    tgt = (target == 14'h0000) ? 14'h0001 : target;
    if (valid) begin
      if (err < win) begin
        if (cur.cnt < tgt) begin
          nx.cnt = cur.cnt + 14'h0001;
        end
        if ({1'b0, cur.cnt} + 15'h0001 >= {1'b0, tgt}) begin
          nx.lock = 1'b1;
        end
      end else begin
        nx.cnt  = 14'h0000;
        nx.lock = 1'b0;
      end
    end
    return nx;
  endfunction

  // one tick of a modulo divider; zero divides as one
  function automatic logic [18:0] div_step(
    input logic [17:0] cnt,
    input logic [17:0] div,
    input logic        tick
  );
    logic [17:0] top;
    top = (div == 18'h00000) ? 18'h00000 : div - 18'h00001;
    if (!tick) begin
      div_step = {1'b0, cnt};
    end else if (cnt >= top) begin
      div_step = {1'b1, 18'h00000};
    end else begin
      div_step = {1'b0, cnt + 18'h00001};
    end
  endfunction

  // status pin multiplexer with optional inversion
  function automatic logic pin_mux(
    input logic [3:0]           sel,
    input logic                 inv,
    input holdover_pkg::flags_s f
  );
    logic v;
    v = 1'b0;
    if (sel == holdover_pkg::SEL_LOOP1_LOCK) begin
      v = f.loop1_lock;
    end else if (sel == holdover_pkg::SEL_LOOP2_LOCK) begin
      v = f.loop2_lock;
    end else if (sel == holdover_pkg::SEL_BOTH_LOCK) begin
      v = f.loop1_lock & f.loop2_lock;
    end else if (sel == holdover_pkg::SEL_HOLDOVER) begin
      v = f.holdover;
    end else if (sel == holdover_pkg::SEL_DAC_LOCKED) begin
      v = f.dac_locked;
    end else if (sel == holdover_pkg::SEL_DAC_RAIL) begin
      v = f.dac_rail;
    end else if (sel == holdover_pkg::SEL_DAC_LOW) begin
      v = f.dac_low;
    end else if (sel == holdover_pkg::SEL_DAC_HIGH) begin
      v = f.dac_high;
    end
    return v ^ inv;
  endfunction

  // next-state logic
  always_comb begin
    logic       force_ho, mode_on, mode_off, lossoff, rail_en;
    logic       track_en, man_en, dbl_en, fell, enter, in_ho;
    logic [DAC_W:0] diff;
    logic [18:0]    r;
    logic           osc_tick;
    force_ho = 1'b0;
    mode_on  = 1'b0;
    mode_off = 1'b0;
    lossoff  = 1'b0;
    rail_en  = 1'b0;
    track_en = 1'b0;
    man_en   = 1'b0;
    dbl_en   = 1'b0;
    fell     = 1'b0;
    enter    = 1'b0;
    in_ho    = 1'b0;
    diff     = '0;
    r        = '0;
    osc_tick = 1'b0;
    d        = q;
    d.rdata  = 32'h0000_0000;
    d.pulses = 4'h0;

    // register writes
    if (reg_wr) begin
      if (reg_addr == holdover_pkg::ADDR_CTRL) begin
        d.ctrl = reg_wdata[7:0];
      end else if (reg_addr == holdover_pkg::ADDR_TRIP) begin
        d.lower_trip = reg_wdata[DAC_W-1:0];
        d.upper_trip = reg_wdata[holdover_pkg::HI_LSB +: DAC_W];
      end else if (reg_addr == holdover_pkg::ADDR_DAC) begin
        d.manual_val  = reg_wdata[DAC_W-1:0];
        d.dac_clk_div = reg_wdata[holdover_pkg::HI_LSB +: 10];
      end else if (reg_addr == holdover_pkg::ADDR_WINDOW) begin
        d.win1 = reg_wdata[PERR_W-1:0];
        d.win2 = reg_wdata[holdover_pkg::HI_LSB +: PERR_W];
      end else if (reg_addr == holdover_pkg::ADDR_COUNT) begin
        d.hold_cnt = reg_wdata[13:0];
        d.cnt2     = reg_wdata[holdover_pkg::HI_LSB +: 14];
      end else if (reg_addr == holdover_pkg::ADDR_PINSEL) begin
        d.pinsel = reg_wdata[12:0];
      end else if (reg_addr == holdover_pkg::ADDR_DIV1) begin
        d.r1_div = reg_wdata[13:0];
        d.n1_div = reg_wdata[holdover_pkg::HI_LSB +: 14];
      end else if (reg_addr == holdover_pkg::ADDR_DIV2A) begin
        d.r2_div = reg_wdata[11:0];
        if (reg_wdata[19:16] < holdover_pkg::PRESC_MIN) begin
          d.presc = holdover_pkg::PRESC_MIN;
        end else if (reg_wdata[19:16] > holdover_pkg::PRESC_MAX) begin
          d.presc = holdover_pkg::PRESC_MAX;
        end else begin
          d.presc = reg_wdata[19:16];
        end
      end else if (reg_addr == holdover_pkg::ADDR_DIV2B) begin
        d.n2_div = reg_wdata[17:0];
      end
    end

    // register reads, answered next cycle; unmapped reads zero
    if (reg_rd) begin
      if (reg_addr == holdover_pkg::ADDR_CTRL) begin
        d.rdata[7:0] = q.ctrl;
      end else if (reg_addr == holdover_pkg::ADDR_TRIP) begin
        d.rdata[DAC_W-1:0] = q.lower_trip;
        d.rdata[holdover_pkg::HI_LSB +: DAC_W] = q.upper_trip;
      end else if (reg_addr == holdover_pkg::ADDR_DAC) begin
        d.rdata[DAC_W-1:0] = q.manual_val;
        d.rdata[holdover_pkg::HI_LSB +: 10] = q.dac_clk_div;
      end else if (reg_addr == holdover_pkg::ADDR_WINDOW) begin
        d.rdata[PERR_W-1:0] = q.win1;
        d.rdata[holdover_pkg::HI_LSB +: PERR_W] = q.win2;
      end else if (reg_addr == holdover_pkg::ADDR_COUNT) begin
        d.rdata[13:0] = q.hold_cnt;
        d.rdata[holdover_pkg::HI_LSB +: 14] = q.cnt2;
      end else if (reg_addr == holdover_pkg::ADDR_PINSEL) begin
        d.rdata[12:0] = q.pinsel;
      end else if (reg_addr == holdover_pkg::ADDR_DIV1) begin
        d.rdata[13:0] = q.r1_div;
        d.rdata[holdover_pkg::HI_LSB +: 14] = q.n1_div;
      end else if (reg_addr == holdover_pkg::ADDR_DIV2A) begin
        d.rdata[11:0]  = q.r2_div;
        d.rdata[19:16] = q.presc;
      end else if (reg_addr == holdover_pkg::ADDR_DIV2B) begin
        d.rdata[17:0] = q.n2_div;
      end else if (reg_addr == holdover_pkg::ADDR_STATUS) begin
        d.rdata[6:0] = q.flags;
      end else if (reg_addr == holdover_pkg::ADDR_TRACKED) begin
        d.rdata[DAC_W-1:0] = q.tracked;
      end
    end

    // decoded controls, from the registered copy
    force_ho = q.ctrl[holdover_pkg::CTRL_FORCE];
    mode_on  = q.ctrl[holdover_pkg::CTRL_MODE_LSB +: 2]
               == holdover_pkg::HOLD_MODE_ON;
    mode_off = q.ctrl[holdover_pkg::CTRL_MODE_LSB +: 2]
               == holdover_pkg::HOLD_MODE_OFF;
    lossoff  = q.ctrl[holdover_pkg::CTRL_LOCKLOSS];
    rail_en  = q.ctrl[holdover_pkg::CTRL_RAIL_EN];
    track_en = q.ctrl[holdover_pkg::CTRL_TRACK_EN];
    man_en   = q.ctrl[holdover_pkg::CTRL_MANUAL_EN];
    dbl_en   = q.ctrl[holdover_pkg::CTRL_DOUBLER_EN];

    // lock detectors; loop1 keeps trying during holdover
    d.det1 = lock_step(q.det1, loop1_cmp_valid, loop1_phase_err,
                       q.win1, q.hold_cnt);
    d.det2 = lock_step(q.det2, loop2_cmp_valid, loop2_phase_err,
                       q.win2, q.cnt2);
    fell = q.det1.lock & ~d.det1.lock;

    // holdover state machine
    case (q.st)
      holdover_pkg::HO_NORMAL: begin
        enter = force_ho;
        enter = enter | (mode_on & ~lossoff & fell);
        enter = enter | (mode_on & rail_en & track_en & man_en
                         & q.flags.dac_rail);
        if (enter) begin
          d.st = holdover_pkg::HO_ACTIVE;
          d.keep2 = q.det2.lock;
          d.det1  = '0;
        end
      end
      holdover_pkg::HO_ACTIVE: begin
        if (!force_ho) begin
          if (mode_off) begin
            d.st = holdover_pkg::HO_NORMAL;
          end else if (d.det1.lock) begin
            d.st = holdover_pkg::HO_NORMAL;
          end
        end
      end
      default: begin
        d.st = holdover_pkg::HO_NORMAL;
      end
    endcase
    in_ho = (d.st == holdover_pkg::HO_ACTIVE);

    if (track_en && loop1_cmp_valid) begin
      r = div_step({8'h00, q.trk_cnt}, {8'h00, q.dac_clk_div}, 1'b1);
      d.trk_cnt = r[9:0];
      if (r[18] && !in_ho) begin
        d.tracked = tune_code;
      end
    end

    if (in_ho && man_en) begin
      d.dac = q.manual_val;
    end else begin
      d.dac = d.tracked;
    end
    d.pump_en = ~in_ho;

    d.flags.dac_low  = tune_code <= q.lower_trip;
    d.flags.dac_high = tune_code >= q.upper_trip;
    d.flags.dac_rail = d.flags.dac_low | d.flags.dac_high;
    diff = (tune_code >= q.tracked)
           ? {1'b0, tune_code} - {1'b0, q.tracked}
           : {1'b0, q.tracked} - {1'b0, tune_code};
    d.flags.dac_locked = track_en
                         & (diff <= (DAC_W+1)'(holdover_pkg::DAC_LOCK_TOL));
    // loop1 lock low, loop2 lock held if locked at entry, and flag in holdover
    d.flags.holdover   = in_ho;
    d.flags.loop1_lock = d.det1.lock & ~in_ho;
    d.flags.loop2_lock = d.det2.lock | (in_ho & d.keep2);

    d.lock_pin = pin_mux(q.pinsel[holdover_pkg::PIN_LOCK_LSB +: 4],
                         q.pinsel[holdover_pkg::PIN_LOCK_INV], d.flags);
    d.hold_pin = pin_mux(q.pinsel[holdover_pkg::PIN_HOLD_LSB +: 4],
                         q.pinsel[holdover_pkg::PIN_HOLD_INV], d.flags);

    r = div_step({4'h0, q.r1_cnt}, {4'h0, q.r1_div}, loop1_ref_tick);
    d.r1_cnt    = r[13:0];
    d.pulses[3] = r[18];
    r = div_step({4'h0, q.n1_cnt}, {4'h0, q.n1_div}, loop1_fb_tick);
    d.n1_cnt    = r[13:0];
    d.pulses[2] = r[18];
    d.osc_prev = oscillator_input;
    osc_tick = dbl_en ? (oscillator_input ^ q.osc_prev)
                      : (oscillator_input & ~q.osc_prev);
    r = div_step({6'h00, q.r2_cnt}, {6'h00, q.r2_div}, osc_tick);
    d.r2_cnt    = r[11:0];
    d.pulses[1] = r[18];
    r = div_step({14'h0000, q.pre_cnt}, {14'h0000, q.presc}, loop2_fb_tick);
    d.pre_cnt = r[3:0];
    r = div_step(q.n2_cnt, q.n2_div, r[18]);
    d.n2_cnt    = r[17:0];
    d.pulses[0] = r[18];
  end

  // state register with synchronous reset
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q          <= '0;
      q.ctrl     <= holdover_pkg::CTRL_RESET[7:0];
      q.win1     <= holdover_pkg::WINDOW_RESET[PERR_W-1:0];
      q.win2     <= holdover_pkg::WINDOW_RESET[PERR_W-1:0];
      q.hold_cnt <= holdover_pkg::COUNT_RESET;
      q.cnt2     <= holdover_pkg::COUNT_RESET;
      q.r1_div   <= holdover_pkg::DIV_RESET;
      q.n1_div   <= holdover_pkg::DIV_RESET;
      q.r2_div   <= holdover_pkg::DIV_RESET[11:0];
      q.n2_div   <= {4'h0, holdover_pkg::DIV_RESET};
      q.presc    <= holdover_pkg::PRESC_RESET;
      q.st       <= holdover_pkg::HO_NORMAL;
      q.pump_en  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from state flip-flops
  assign reg_rdata            = q.rdata;
  assign loop1_charge_pump_en = q.pump_en;
  assign dac_value            = q.dac;
  assign status_flags         = q.flags;
  assign lock_status_pin      = q.lock_pin;
  assign holdover_status_pin  = q.hold_pin;
  assign loop1_r_pulse        = q.pulses[3];
  assign loop1_n_pulse        = q.pulses[2];
  assign loop2_r_pulse        = q.pulses[1];
  assign loop2_n_pulse        = q.pulses[0];

endmodule

// ### core/holdover_pkg.sv
// Purpose: shared constants and carrier types of the holdover and lock block
// Assumes: register port with a 4-bit word address and 32-bit data
// Notes:   field positions are bit indices inside the 32-bit data word
package holdover_pkg;

  // register word addresses
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_TRIP    = 4'h1;
  localparam logic [3:0] ADDR_DAC     = 4'h2;
  localparam logic [3:0] ADDR_WINDOW  = 4'h3;
  localparam logic [3:0] ADDR_COUNT   = 4'h4;
  localparam logic [3:0] ADDR_PINSEL  = 4'h5;
  localparam logic [3:0] ADDR_DIV1    = 4'h6;
  localparam logic [3:0] ADDR_DIV2A   = 4'h7;
  localparam logic [3:0] ADDR_DIV2B   = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'h9;
  localparam logic [3:0] ADDR_TRACKED = 4'hA;

  // control register bit positions
  localparam int CTRL_FORCE      = 0;
  localparam int CTRL_MODE_LSB   = 1;   // two bits
  localparam int CTRL_LOCKLOSS   = 3;
  localparam int CTRL_RAIL_EN    = 4;
  localparam int CTRL_TRACK_EN   = 5;
  localparam int CTRL_MANUAL_EN  = 6;
  localparam int CTRL_DOUBLER_EN = 7;

  // upper field position shared by the two-field registers
  localparam int HI_LSB = 16;
  // pin selector fields inside the pin select register
  localparam int PIN_LOCK_LSB = 0;    // four-bit selector
  localparam int PIN_LOCK_INV = 4;
  localparam int PIN_HOLD_LSB = 8;    // four-bit selector
  localparam int PIN_HOLD_INV = 12;

  // holdover mode encodings
  localparam logic [1:0] HOLD_MODE_OFF = 2'h0;
  localparam logic [1:0] HOLD_MODE_ON  = 2'h2;

  // reset values and prescaler limits
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [13:0] COUNT_RESET  = 14'h0400;
  localparam logic [7:0]  WINDOW_RESET = 8'h10;
  localparam logic [13:0] DIV_RESET    = 14'h0001;
  localparam logic [3:0]  PRESC_RESET  = 4'h2;
  localparam logic [3:0]  PRESC_MIN    = 4'h2;
  localparam logic [3:0]  PRESC_MAX    = 4'h8;

  // dac considered locked while within this many codes of the tuning level
  localparam int DAC_LOCK_TOL = 2;

  // status pin selections
  typedef enum logic [3:0] {
    SEL_LOW        = 4'h0,
    SEL_LOOP1_LOCK = 4'h1,
    SEL_LOOP2_LOCK = 4'h2,
    SEL_BOTH_LOCK  = 4'h3,
    SEL_HOLDOVER   = 4'h4,
    SEL_DAC_LOCKED = 4'h5,
    SEL_DAC_RAIL   = 4'h6,
    SEL_DAC_LOW    = 4'h7,
    SEL_DAC_HIGH   = 4'h8
  } pin_sel_e;

  // holdover state machine, one-hot
  typedef enum logic [1:0] {
    HO_NORMAL = 2'b01,
    HO_ACTIVE = 2'b10
  } ho_state_e;

  // one lock detector: comparison count and lock indication
  typedef struct packed {
    logic [13:0] cnt;
    logic        lock;
  } lockdet_s;

  // status flags offered to the status pins
  typedef struct packed {
    logic dac_high;
    logic dac_low;
    logic dac_rail;
    logic dac_locked;
    logic holdover;
    logic loop2_lock;
    logic loop1_lock;
  } flags_s;

endpackage

// ### dv/ref_source_model.sv
// Purpose: reference sources and phase comparisons seen by both loops
// Assumes: bench picks spacing and error magnitudes
// Notes:   error lines scramble between comparisons
`timescale 1ns/1ps
module ref_source_model (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rstn,
  // chosen behaviour: slow with a large gap
  input  wire logic [3:0] gap,
  input  wire logic [7:0] err1,
  input  wire logic [7:0] err2,
  // toward the device
  output logic            v1,
  output logic [7:0]      e1,
  output logic            v2,
  output logic [7:0]      e2,
  output logic            osc
);
  logic [3:0] cnt_q;  // spacing counter
  wire        hit = cnt_q >= gap;
  // one comparison per loop every gap cycles
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      cnt_q <= 4'h1;
      {v1, v2, osc} <= 3'h0;
      e1 <= 8'h00;
      e2 <= 8'h00;
    end else begin
      cnt_q <= hit ? 4'h1 : cnt_q + 4'h1;
      v1 <= hit;
      v2 <= hit;
      // off a comparison the lines carry no meaning
      e1 <= hit ? err1 : ~e1;
      e2 <= hit ? err2 : ~e2;
      osc <= ~osc;
    end
  end
endmodule

// ### dv/holdover_monitor.sv
// Purpose: port-level checks of holdover, lock and dac flags
// Assumes: settings snooped from register writes
// Notes:   run_q mirrors the loop1 in-window count
`timescale 1ns/1ps
module holdover_monitor #(
  parameter int DAC_W  = 10,
  parameter int PERR_W = 8
) (
  // clock and reset
  input wire logic                 core_clk,
  input wire logic                 rstn,
  // register writes
  input wire logic [3:0]           reg_addr,
  input wire logic [31:0]          reg_wdata,
  input wire logic                 reg_wr,
  // loop1 comparisons
  input wire logic                 loop1_cmp_valid,
  input wire logic [PERR_W-1:0]    loop1_phase_err,
  // watched outputs
  input wire logic                 loop1_charge_pump_en,
  input wire logic [DAC_W-1:0]     dac_value,
  input wire holdover_pkg::flags_s status_flags,
  input wire logic                 holdover_status_pin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [7:0]       ctl_q;   // control word
  logic [7:0]       win_q;   // loop1 window
  logic [13:0]      tgt_q;   // loop1 target
  logic [4:0]       hsel_q;  // holdover pin selector and invert
  logic [DAC_W-1:0] man_q;   // manual dac code
  logic [14:0]      run_q;   // in-window run
  wire in1 = loop1_phase_err < win_q;
  wire [14:0] need = (tgt_q == 14'h0000) ? 15'h0001 : {1'b0, tgt_q};
  wire ctl_wr = reg_wr && reg_addr == holdover_pkg::ADDR_CTRL;
  // snoop writes, count in-window comparisons
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctl_q <= 8'h00;
      win_q <= 8'h10;
      tgt_q <= 14'h0400;
      hsel_q <= 5'h00;
      man_q <= '0;
      run_q <= 15'h0000;
    end else begin
      if (ctl_wr) ctl_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == holdover_pkg::ADDR_WINDOW)
        win_q <= reg_wdata[7:0];
      if (reg_wr && reg_addr == holdover_pkg::ADDR_COUNT)
        tgt_q <= reg_wdata[13:0];
      if (reg_wr && reg_addr == holdover_pkg::ADDR_PINSEL)
        hsel_q <= reg_wdata[12:8];
      if (reg_wr && reg_addr == holdover_pkg::ADDR_DAC)
        man_q <= reg_wdata[DAC_W-1:0];
      if (loop1_cmp_valid) run_q <= in1 ? run_q + 15'h0001 : 15'h0000;
    end
  end
  a_force_enter: assert property (ctl_wr && reg_wdata[0] |->
    ##[1:3] status_flags.holdover) else $error("force ignored");
  a_hold_pump: assert property (status_flags.holdover !=
    loop1_charge_pump_en) else $error("pump vs holdover");
  a_hold_lock1: assert property (status_flags.holdover |->
    !status_flags.loop1_lock) else $error("loop1 lock in holdover");
  a_rail_or: assert property (status_flags.dac_rail ==
    (status_flags.dac_low | status_flags.dac_high)) else $error("rail");
  a_hold_pin: assert property ($rose(status_flags.holdover) &&
    hsel_q == 5'h04 |-> ##[0:1] holdover_status_pin) else $error("pin");
  a_dac_manual: assert property ($rose(status_flags.holdover) &&
    ctl_q[6] |-> ##[0:1] dac_value == man_q) else $error("dac drive");
  a_mode_exit: assert property (ctl_wr && reg_wdata[2:0] == 3'h0
    |-> ##[1:3] !status_flags.holdover) else $error("no exit");
  a_lock_drop: assert property (loop1_cmp_valid && !in1 &&
    need > 15'h0001 |-> ##2 !status_flags.loop1_lock) else $error("drop");
  a_lock_count: assert property ($rose(status_flags.loop1_lock)
    |-> run_q >= need) else $error("early lock");
  c_hold: cover property ($rose(status_flags.holdover));
  c_drop: cover property ($fell(status_flags.loop1_lock));
  c_rail: cover property ($rose(status_flags.dac_rail));
endmodule
bind holdover_lock_detect_status holdover_monitor #(.DAC_W(DAC_W),
  .PERR_W(PERR_W)) u_holdover_monitor (.core_clk(core_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .loop1_cmp_valid(loop1_cmp_valid), .loop1_phase_err(loop1_phase_err),
  .loop1_charge_pump_en(loop1_charge_pump_en), .dac_value(dac_value),
  .status_flags(status_flags), .holdover_status_pin(holdover_status_pin));

// ### dv/tb_top.sv
// Purpose: self-checking bench of the holdover and lock block
// Assumes: register port strobes driven after rising edges
// Notes:   random phase errors come from a fixed-seed shift register
`timescale 1ns/1ps
module tb_top;
  logic core_clk, rstn, reg_wr, reg_rd, g1, g2, gosc, pump, lpin, hpin;
  logic [3:0] reg_addr, gap;
  logic [31:0] reg_wdata, reg_rdata, rnd;
  logic [7:0] err1, err2, e1, e2;
  logic [9:0] tune_code, dac;
  holdover_pkg::flags_s sf;
  int fail_count, n_compared, i;
  ref_source_model u_ref_source_model (.core_clk(core_clk), .rstn(rstn),
    .gap(gap), .err1(err1), .err2(err2), .v1(g1), .e1(e1), .v2(g2),
    .e2(e2), .osc(gosc));
  holdover_lock_detect_status u_holdover_lock_detect_status (
    .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .loop1_cmp_valid(g1), .loop1_phase_err(e1),
    .loop2_cmp_valid(g2), .loop2_phase_err(e2), .tune_code(tune_code),
    .loop1_ref_tick(g1), .loop1_fb_tick(gosc), .oscillator_input(gosc),
    .loop2_fb_tick(g2), .loop1_charge_pump_en(pump), .dac_value(dac),
    .status_flags(sf), .lock_status_pin(lpin), .holdover_status_pin(hpin),
    .loop1_r_pulse(), .loop1_n_pulse(), .loop2_r_pulse(), .loop2_n_pulse());
  // free running clock
  always #10 core_clk = ~core_clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // expected lock pin level for a selector
  function automatic logic pin_exp(input logic [3:0] s, input logic inv);
    return ((s == 4'h1) | (s == 4'h3 && sf.loop2_lock)) ^ inv;
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk_word(reg_rdata, exp);
  endtask
  // wait bounded for masked flags, then compare
  task automatic flags_to(input logic [6:0] m, input logic [6:0] v);
    #1;
    for (int k = 0; k < 300 && (sf & m) !== v; k++) #20;
    chk_word({25'h0, sf & m}, {25'h0, v});
    $display("test flags %h done", v);
    @(posedge core_clk);
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    close_out();
  end
  initial begin
    {core_clk, rstn, reg_wr, reg_rd} = 4'h0;
    {reg_addr, reg_wdata, tune_code} = '0;
    {gap, err1, err2, rnd} = {4'h4, 8'h01, 8'h01, 32'h5694};
    tune_code = 10'h200;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rd(4'h3, 32'h0010_0010);
    rd(4'h4, 32'h0400_0400);
    rd(4'h6, 32'h0001_0001);
    wr(4'hC, 32'hFFFF_FFFF);
    rd(4'hC, 32'h0000_0000);
    for (i = 0; i < 11; i++) begin
      wr(4'h7, {12'h0, i[3:0], 16'h0002});
      rd(4'h7, {12'h0, (i < 2) ? 4'h2 : (i > 8) ? 4'h8 : i[3:0], 16'h0002});
    end
    wr(4'h4, 32'h0003_0003);
    flags_to(7'h03, 7'h03);
    err2 <= 8'h10;
    flags_to(7'h03, 7'h01);
    for (i = 0; i < 8; i++) begin
      wr(4'h5, {27'h0, i[0], 1'b0, i[3:1]});
      repeat (3) @(posedge core_clk);
      #1 chk_word({31'h0, lpin},
        {31'h0, pin_exp({1'b0, i[3:1]}, i[0])});
    end
    err2 <= 8'h01;
    gap <= 4'h8;
    for (i = 0; i < 40; i++) begin
      rnd = lfsr_next(rnd);
      err1 <= (rnd[1:0] == 2'h0) ? 8'h10 : {4'h0, rnd[5:2]};
      repeat (8) @(posedge core_clk);
    end
    err1 <= 8'h01;
    flags_to(7'h03, 7'h03);
    wr(4'h2, 32'h0000_0155);
    wr(4'h5, 32'h0000_0400);
    wr(4'h0, 32'h0000_0041);
    flags_to(7'h07, 7'h06);
    #1 chk_word({22'h0, dac, hpin, pump}, 32'h0000_0556);
    wr(4'h0, 32'h0000_0000);
    flags_to(7'h07, 7'h03);
    wr(4'h0, 32'h0000_0004);
    err1 <= 8'hFF;
    flags_to(7'h05, 7'h04);
    err1 <= 8'h01;
    flags_to(7'h05, 7'h01);
    wr(4'h1, 32'h0300_0010);
    flags_to(7'h70, 7'h00);
    tune_code <= 10'h3F0;
    flags_to(7'h70, 7'h50);
    tune_code <= 10'h005;
    flags_to(7'h70, 7'h30);
    wr(4'h0, 32'h0000_007C);
    flags_to(7'h04, 7'h04);
    tune_code <= 10'h200;
    wr(4'h0, 32'h0000_0020);
    flags_to(7'h0C, 7'h08);
    rd(4'hA, 32'h0000_0200);
    close_out();
  end
endmodule
